// file: logic/drq_regs.vh
`ifndef DRQ_REGS_VH
`define DRQ_REGS_VH
// Register byte addresses
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WDD         8'h08
`define REG_CMDCNT      8'h0C
`define REG_LASTCMD     8'h10
// Control fields
`define CTRL_ENABLE     0
`define CTRL_CLR_CNT    1
// Reset values
`define CTRL_RESET      2'h1
`define WDD_RESET       4'h4
// Request packet opcodes (request_pins[11:10])
`define OP_NOP          2'h0
`define OP_ACT          2'h1
`define OP_COL          2'h2
`define OP_ROW_PRECHARGE_PACKET         2'h3
// Command codes issued after delay
`define CMD_ACT         3'h1
`define CMD_RD          3'h2
`define CMD_WR          3'h3
`define CMD_PRE         3'h4
`define CMD_REFRESH_PRECHARGE_COMMAND        3'h5
`define CMD_REFRESH_ACTIVATE_COMMAND        3'h6
`define CMD_REFRESH_INCREMENT_COMMAND        3'h7
// Timing
`define CLK_PERIOD_NS   8
`define WDD_MAX         15
`endif

// file: logic/drq_fifo.v
`timescale 1ns/1ns
module drq_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Fill side
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    // Drain side
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = in_valid_i && in_ready_o;
    wire            pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // drq_fifo

// file: logic/drq_sched.v
`timescale 1ns/1ns
`include "drq_regs.vh"
// Overview of operation
// - Delay fields postpone commands whole cycles
// - Activate delay one equals later activate
// - Column delay one equals later column
// - Read data timed from virtual command
// - Write data sampled from virtual command
// - Precharge delay from two-bit delay field
// - Refresh delay from its own two-bit delay field
// - Refresh activate/increment share same delay
// - Row precharge decodes two independent operations
// - Each operation delayed by own field
// - Write data follows by write delay
module drq_sched #(
    parameter DW    = 16,
    parameter DEPTH = 16
) (
    // System
    input  wire          clk_i,
    input  wire          rst_i,
    // Link pins
    input  wire          clock_from_master_i,
    input  wire [11:0]   request_pins_i,
    input  wire [DW-1:0] data_pins_i,
    // Classic Wishbone slave
    input  wire          cyc_i,
    input  wire          stb_i,
    input  wire          we_i,
    input  wire [7:0]    adr_i,
    input  wire [3:0]    sel_i,
    input  wire [31:0]   dat_i,
    output reg  [31:0]   dat_o,
    output reg           ack_o,
    // Issued command stream
    output reg           cmd_valid_o,
    output reg  [2:0]    cmd_code_o,
    output reg  [2:0]    cmd_bank_o,
    output reg           read_data_o,
    // Write data stream
    output reg  [DW-1:0] wdata_o,
    output reg           wdata_valid_o,
    input  wire          wdata_ready_i,
    output reg           overflow_o
);
    // Three-stage synchronisers
    reg [2:0]    cfm_s;
    reg          cfm_prev;
    reg [11:0]   rq_s1;
    reg [11:0]   rq_s2;
    reg [11:0]   rq_s3;
    reg [DW-1:0] dq_s1;
    reg [DW-1:0] dq_s2;
    reg [DW-1:0] dq_s3;
    wire         cfm_level = cfm_s[1];
    wire         cfm_agree = (cfm_s[1] == cfm_s[2]);
    wire         link_edge = cfm_agree && cfm_level && !cfm_prev;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cfm_s    <= 3'h0;
            cfm_prev <= 1'b0;
            rq_s1    <= 12'h000;
            rq_s2    <= 12'h000;
            rq_s3    <= 12'h000;
            dq_s1    <= {DW{1'b0}};
            dq_s2    <= {DW{1'b0}};
            dq_s3    <= {DW{1'b0}};
        end else begin
            cfm_s <= {cfm_s[1:0], clock_from_master_i};
            if (cfm_agree) begin
                cfm_prev <= cfm_level;
            end
            rq_s1 <= request_pins_i;
            rq_s2 <= rq_s1;
            rq_s3 <= rq_s2;
            dq_s1 <= data_pins_i;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    // Registers
    reg [1:0]  ctrl;
    reg [3:0]  wdd;
    reg [15:0] cmd_count;
    reg [7:0]  last_cmd;
    wire       enable = ctrl[`CTRL_ENABLE];
    wire       bus_req = cyc_i && stb_i && !ack_o;

    // Delay slot per command kind: {valid, code, bank, remaining}
    // Slot 0 activate/column, slot 1 precharge, slot 2 refresh
    reg        slot_v   [0:2];
    reg [2:0]  slot_cmd [0:2];
    reg [2:0]  slot_bank[0:2];
    reg [1:0]  slot_cnt [0:2];

    // Packet decode: [11:10] opcode
    wire [1:0] opc = rq_s2[11:10];
    wire       pkt = link_edge && enable && (opc != `OP_NOP);

    // Write data countdown
    reg [3:0]  wd_cnt;
    reg        wd_pend;

    function [2:0] refresh_code;
        input [1:0] refresh_operation_field;
        begin
            case (refresh_operation_field)
                2'h1:    refresh_code = `CMD_REFRESH_PRECHARGE_COMMAND;
                2'h2:    refresh_code = `CMD_REFRESH_ACTIVATE_COMMAND;
                default: refresh_code = `CMD_REFRESH_INCREMENT_COMMAND;
            endcase
        end
    endfunction

    // Slot readiness at a link edge
    wire rdy0 = slot_v[0] && (slot_cnt[0] == 2'h0);
    wire rdy1 = slot_v[1] && (slot_cnt[1] == 2'h0);
    wire rdy2 = slot_v[2] && (slot_cnt[2] == 2'h0);

    // FIFO in the write data path
    wire          fifo_in_ready;
    wire [DW-1:0] fifo_data;
    wire          fifo_valid;
    reg           fifo_push;
    reg  [DW-1:0] fifo_wdata;
    wire          fifo_pop = fifo_valid && (!wdata_valid_o || wdata_ready_i);

    drq_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(4)) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (fifo_wdata),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < 3; i = i + 1) begin
                slot_v[i]    <= 1'b0;
                slot_cmd[i]  <= 3'h0;
                slot_bank[i] <= 3'h0;
                slot_cnt[i]  <= 2'h0;
            end
            cmd_valid_o <= 1'b0;
            cmd_code_o  <= 3'h0;
            cmd_bank_o  <= 3'h0;
            read_data_o <= 1'b0;
            wd_cnt      <= 4'h0;
            wd_pend     <= 1'b0;
            fifo_push   <= 1'b0;
            fifo_wdata  <= {DW{1'b0}};
            overflow_o  <= 1'b0;
            cmd_count   <= 16'h0000;
            last_cmd    <= 8'h00;
        end else begin
            cmd_valid_o <= 1'b0;
            read_data_o <= 1'b0;
            fifo_push   <= 1'b0;
            if (ack_o == 1'b0 && bus_req && we_i && adr_i == `REG_CTRL
                    && sel_i[0] && dat_i[`CTRL_CLR_CNT]) begin
                overflow_o <= 1'b0;
                cmd_count  <= 16'h0000;
            end
            if (link_edge) begin
                // Count down pending slots one link cycle each
                for (i = 0; i < 3; i = i + 1) begin
                    if (slot_v[i] && slot_cnt[i] != 2'h0) begin
                        slot_cnt[i] <= slot_cnt[i] - 2'h1;
                    end
                end
                // Issue: activate/column wins the output, then precharge; others retry at the next link edge
                if (rdy0 || rdy1 || rdy2) begin
                    cmd_valid_o <= 1'b1;
                    cmd_count   <= cmd_count + 16'h0001;
                end
                if (rdy0) begin
                    slot_v[0]  <= 1'b0;
                    cmd_code_o <= slot_cmd[0];
                    cmd_bank_o <= slot_bank[0];
                    last_cmd   <= {2'h0, slot_cmd[0], slot_bank[0]};
                    // Read data timed from virtual position
                    read_data_o <= (slot_cmd[0] == `CMD_RD);
                end else if (rdy1) begin
                    slot_v[1]  <= 1'b0;
                    cmd_code_o <= slot_cmd[1];
                    cmd_bank_o <= slot_bank[1];
                    last_cmd   <= {2'h0, slot_cmd[1], slot_bank[1]};
                end else if (rdy2) begin
                    slot_v[2]  <= 1'b0;
                    cmd_code_o <= slot_cmd[2];
                    cmd_bank_o <= slot_bank[2];
                    last_cmd   <= {2'h0, slot_cmd[2], slot_bank[2]};
                end
                if (rdy0 && rdy1) begin
                    slot_v[1]   <= 1'b1;
                    slot_cnt[1] <= 2'h0;
                end
                if ((rdy0 || rdy1) && rdy2) begin
                    slot_v[2]   <= 1'b1;
                    slot_cnt[2] <= 2'h0;
                end
                // Write data sampled at the delayed slot
                if (wd_pend) begin
                    if (wd_cnt == 4'h0) begin
                        wd_pend <= 1'b0;
                        if (fifo_in_ready) begin
                            fifo_push  <= 1'b1;
                            fifo_wdata <= dq_s2;
                        end else begin
                            overflow_o <= 1'b1;
                        end
                    end else begin
                        wd_cnt <= wd_cnt - 4'h1;
                    end
                end
                if (pkt) begin
                    case (opc)
                        `OP_ACT: begin
                            // [9] delay bit, [8:6] bank; single bit
                            slot_v[0]    <= 1'b1;
                            slot_cmd[0]  <= `CMD_ACT;
                            slot_bank[0] <= rq_s2[8:6];
                            slot_cnt[0]  <= {1'b0, rq_s2[9]};
                        end
                        `OP_COL: begin
                            // [9] delay bit, [5] write, [8:6] bank
                            slot_v[0]    <= 1'b1;
                            slot_cmd[0]  <= rq_s2[5] ? `CMD_WR : `CMD_RD;
                            slot_bank[0] <= rq_s2[8:6];
                            slot_cnt[0]  <= {1'b0, rq_s2[9]};
                            if (rq_s2[5]) begin
                                // Data slot counted from virtual position
                                // A zero write data delay is not supported
                                wd_cnt  <= wdd + {3'h0, rq_s2[9]} - 4'h1;
                                wd_pend <= 1'b1;
                            end
                        end
                        `OP_ROW_PRECHARGE_PACKET: begin
                            // Two independent operations
                            if (rq_s2[9]) begin
                                // Precharge: [9] enable, [8:7] delay, [2:0] bank
                                slot_v[1]    <= 1'b1;
                                slot_cmd[1]  <= `CMD_PRE;
                                slot_bank[1] <= rq_s2[2:0];
                                slot_cnt[1]  <= rq_s2[8:7];
                            end
                            if (rq_s2[6:5] != 2'h0) begin
                                // Refresh: [6:5] op, [4:3] delay
                                slot_v[2]    <= 1'b1;
                                slot_cmd[2]  <= refresh_code(rq_s2[6:5]);
                                slot_bank[2] <= 3'h0;
                                slot_cnt[2]  <= rq_s2[4:3];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Write data output stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            wdata_o       <= {DW{1'b0}};
            wdata_valid_o <= 1'b0;
        end else if (fifo_pop) begin
            wdata_o       <= fifo_data;
            wdata_valid_o <= 1'b1;
        end else if (wdata_ready_i) begin
            wdata_valid_o <= 1'b0;
        end
    end

    // Wishbone register access, ack one cycle after request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            ctrl  <= `CTRL_RESET;
            wdd   <= `WDD_RESET;
        end else begin
            ack_o <= bus_req;
            dat_o <= 32'h00000000;
            if (bus_req && we_i && sel_i[0]) begin
                case (adr_i)
                    `REG_CTRL: ctrl[`CTRL_ENABLE] <= dat_i[`CTRL_ENABLE];
                    `REG_WDD:  wdd <= dat_i[3:0];
                    default: begin
                    end
                endcase
            end
            if (bus_req && !we_i) begin
                case (adr_i)
                    `REG_CTRL:    dat_o <= {30'h0, ctrl};
                    `REG_STATUS:  dat_o <= {26'h0, overflow_o, fifo_valid,
                                            wd_pend, slot_v[2], slot_v[1], slot_v[0]};
                    `REG_WDD:     dat_o <= {28'h0, wdd};
                    `REG_CMDCNT:  dat_o <= {16'h0, cmd_count};
                    `REG_LASTCMD: dat_o <= {24'h0, last_cmd};
                    default:      dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // drq_sched

// file: tb/drq_sched_asserts.sv
`timescale 1ns/1ns
`include "drq_regs.vh"
module drq_sched_asserts #(
    parameter DW = 16
) (
    // System
    input wire          clk_i,
    input wire          rst_i,
    input wire          clock_from_master_i,
    // Bus
    input wire          cyc_i,
    input wire          stb_i,
    input wire          we_i,
    input wire [7:0]    adr_i,
    input wire [31:0]   dat_i,
    input wire          ack_o,
    // Streams
    input wire          cmd_valid_o,
    input wire [2:0]    cmd_code_o,
    input wire [2:0]    cmd_bank_o,
    input wire          read_data_o,
    input wire [DW-1:0] wdata_o,
    input wire          wdata_valid_o,
    input wire          wdata_ready_i,
    input wire          overflow_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       link_q;
    logic [3:0] since;
    // Cycles since the last raw link rise
    always @(posedge clk_i) begin
        link_q <= clock_from_master_i;
        if (rst_i)
            since <= 4'hF;
        else if (clock_from_master_i && !link_q)
            since <= 4'h0;
        else if (since != 4'hF)
            since <= since + 4'h1;
    end
    property p_cpl; cmd_valid_o |=> !cmd_valid_o; endproperty
    property p_lnk; cmd_valid_o |-> since < 4'h8; endproperty
    property p_cod; cmd_valid_o |-> cmd_code_o != 3'h0; endproperty
    property p_hld; !cmd_valid_o |-> $stable(cmd_code_o) && $stable(cmd_bank_o); endproperty
    property p_rdm; read_data_o == (cmd_valid_o && cmd_code_o == `CMD_RD); endproperty
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    property p_wdh; wdata_valid_o && !wdata_ready_i |=> wdata_valid_o && $stable(wdata_o);
    endproperty
    property p_ovf; overflow_o && !(cyc_i && stb_i && we_i && adr_i == `REG_CTRL && dat_i[1])
        |=> overflow_o; endproperty
    a_cpl: assert property (p_cpl) else $error("command pulse too long");
    a_lnk: assert property (p_lnk) else $error("command away from link edge");
    a_cod: assert property (p_cod) else $error("empty command code");
    a_hld: assert property (p_hld) else $error("command fields moved");
    a_rdm: assert property (p_rdm) else $error("read mark mismatch");
    a_ack: assert property (p_ack) else $error("bus answer late");
    a_wdh: assert property (p_wdh) else $error("write word dropped");
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    c_pre: cover property (cmd_valid_o && cmd_code_o == `CMD_PRE);
    c_rfi: cover property (cmd_valid_o && cmd_code_o == `CMD_REFRESH_INCREMENT_COMMAND);
    c_ovf: cover property ($rose(overflow_o));
endmodule // drq_sched_asserts
bind drq_sched drq_sched_asserts #(.DW(DW)) chk (.clk_i(clk_i), .rst_i(rst_i),
    .clock_from_master_i(clock_from_master_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .cmd_valid_o(cmd_valid_o),
    .cmd_code_o(cmd_code_o), .cmd_bank_o(cmd_bank_o), .read_data_o(read_data_o),
    .wdata_o(wdata_o), .wdata_valid_o(wdata_valid_o), .wdata_ready_i(wdata_ready_i),
    .overflow_o(overflow_o));

// file: tb/ctl_model.sv
`timescale 1ns/1ns
module ctl_model (
    // Clock
    input  wire         clk_i,
    // Link pins
    output logic        link_o,
    output logic [11:0] req_o,
    output logic [15:0] dq_o
);
    int edges = 0;
    initial begin
        link_o = 1'b0;
        req_o = 12'h000;
        dq_o = 16'h0000;
    end
    // One packet per link edge, slot data on the same edge
    task automatic send(input [11:0] p, input [15:0] d);
        @(posedge clk_i);
        req_o <= p;
        dq_o <= d;
        repeat (3) @(posedge clk_i);
        link_o <= 1'b1;
        edges++;
        repeat (4) @(posedge clk_i);
        link_o <= 1'b0;
        req_o <= ~p;
        dq_o <= ~d;
    endtask
endmodule // ctl_model

// file: tb/dram_request_delay_and_write_sequencing_test.sv
`timescale 1ns/1ns
`include "drq_regs.vh"
module dram_request_delay_and_write_sequencing_test;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rdy = 0, stall = 0;
    logic [3:0]  sel = 0;
    logic [7:0]  adr = 0;
    logic [31:0] dat = 0;
    wire  [31:0] rd;
    wire  [15:0] wd, dp;
    wire  [11:0] pk;
    wire  [2:0]  cc, cb;
    wire         ack, cv, rdv, wv, ovf, lk;
    logic [21:0] cq[$];
    logic [31:0] bq[$];
    logic [15:0] dq[$];
    int          num_errors = 0, comparisons = 0, cycles = 0, i;
    logic [2:0]  b;
    logic [1:0]  r;
    initial forever #4 clk = ~clk;
    ctl_model ctl (.clk_i(clk), .link_o(lk), .req_o(pk), .dq_o(dp));
    drq_sched uut (.clk_i(clk), .rst_i(rst), .clock_from_master_i(lk), .request_pins_i(pk),
        .data_pins_i(dp), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(rd), .ack_o(ack), .cmd_valid_o(cv), .cmd_code_o(cc),
        .cmd_bank_o(cb), .read_data_o(rdv), .wdata_o(wd), .wdata_valid_o(wv),
        .wdata_ready_i(rdy), .overflow_o(ovf));
    task tally_and_finish;
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Expected command one link edge after its virtual position; refresh bank not compared
    task ex(input int dl, input [2:0] c, input [2:0] bk);
        cq.push_back({16'(ctl.edges + 2 + dl), c, (c > 3'h4) ? 3'h0 : bk});
    endtask
    task fl(input int n);
        repeat (n) ctl.send(12'h000, 16'($urandom));
    endtask
    task wr(input bit dl, input [2:0] bk, input int wdd);
        logic [15:0] d;
        d = 16'($urandom);
        dq.push_back(d);
        ex(dl, `CMD_WR, bk);
        ctl.send({2'h2, dl, bk, 1'b1, 5'h00}, 16'($urandom));
        fl(dl + wdd - 1);
        ctl.send(12'h000, d);
    endtask
    task automatic wb(input bit w, input [7:0] a, input [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        if (!w)
            bq.push_back(d);
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task dr;
        repeat (3000) if (dq.size() > 0) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish;
        end
        rdy <= stall ? 1'b0 : 1'($urandom);
        if (cv)
            chk({16'(ctl.edges), cc, (cc > 3'h4) ? 3'h0 : cb},
                cq.size() ? cq.pop_front() : 'x);
        if (wv && rdy)
            chk(wd, dq.size() ? dq.pop_front() : 'x);
        if (ack && !we)
            chk(rd, bq.size() ? bq.pop_front() : 'x);
    end
    initial begin
        void'($urandom(39278));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        wb(0, `REG_CTRL, 32'h1);
        wb(0, `REG_WDD, `WDD_RESET);
        wb(1, 8'h14, 32'hFF);
        wb(0, 8'h14, 32'h0);
        for (i = 0; i < 2; i++) begin
            b = 3'($urandom);
            ex(i, `CMD_ACT, b);
            ctl.send({2'h1, i[0], b, 6'h00}, 16'h0);
            fl(i);
            ex(i, `CMD_RD, b);
            ctl.send({2'h2, i[0], b, 6'h00}, 16'h0);
            fl(3);
            wr(i[0], b, 4);
        end
        for (i = 0; i < 4; i++) begin
            b = 3'($urandom);
            r = 2'(i % 3 + 1);
            if (i < 2)
                ex(i, `CMD_PRE, b);
            ex(3 - i, 3'h4 + r, b);
            if (i > 1)
                ex(i, `CMD_PRE, b);
            ctl.send({2'h3, 1'b1, 2'(i), r, 2'(3 - i), b}, 16'h0);
            // Four idle edges after each row precharge packet, spaced past both commands
            fl(4);
        end
        dr;
        wb(1, `REG_WDD, 32'h1);
        stall <= 1'b1;
        for (i = 0; i < 18; i++) begin
            if (i == 17) begin
                fl(1);
                chk(ovf, 0);
            end
            wr(0, 3'(i), 1);
        end
        void'(dq.pop_back());
        fl(1);
        chk(ovf, 1);
        stall <= 1'b0;
        dr;
        wb(1, `REG_CTRL, 32'h3);
        chk(ovf, 0);
        wb(0, `REG_CMDCNT, 32'h0);
        wb(1, `REG_CTRL, 32'h0);
        ctl.send({2'h1, 1'b0, 3'h2, 6'h00}, 16'h0);
        fl(2);
        wb(1, `REG_CTRL, 32'h1);
        ex(0, `CMD_ACT, 3'h5);
        ctl.send({2'h1, 1'b0, 3'h5, 6'h00}, 16'h0);
        fl(2);
        chk(cq.size(), 0);
        chk(dq.size(), 0);
        tally_and_finish;
    end
endmodule // dram_request_delay_and_write_sequencing_test
